// *** vam_ctrl.sv ***
// Voltage angle memory controller with Wishbone register slave
`include "vam_regs.svh"
module vam_ctrl (
  input wire logic clk_i, // System clock, 125 MHz
  input wire logic rst_i, // Synchronous reset
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [31:0] wb_dat_i, // Write data
  input wire logic [3:0] wb_sel_i, // Byte enables
  input wire logic wb_we_i, // Write strobe
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Strobe
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire logic tick_i, // Program cycle tick
  input wire logic blk_i, // Memory blocking input
  input wire logic [2:0][15:0] volt_i, // Voltage magnitudes, 0.01 V
  input wire logic [2:0][15:0] curr_i, // Phase current magnitudes
  input wire logic [2:0][15:0] ang_i, // Voltage angles, 0.01 deg
  input wire logic [16:0] trk_freq_i, // Tracked system frequency, mHz
  input wire logic [16:0] il3_freq_i, // Frequency from L3 current, mHz
  output logic [2:0][15:0] amp_o, // Voltage amplitude to stages
  output logic [2:0][15:0] ang_ref_o, // Angle reference to stages
  output logic mem_on_o, // Memory in use
  output logic unidir_o, // Stages fall back to unidirectional
  output logic freq_from_ct_o, // Sampling follows current channel
  output logic [16:0] samp_freq_o, // Stage sampling frequency, mHz
  output logic [16:0] fprot_freq_o, // Frequency protection input, mHz
  output logic [2:0] cal_pt_o, // Correction point index
  output logic [11:0] evt_o // On/off event pulses
);
  vam_pkg::vam_top_t s_q;
  vam_pkg::vam_top_t s_d;
  vam_tmr_if tif ();

  logic en;
  logic low_v;
  logic oc_hit;
  logic cond;
  logic blk_now;
  logic engage;
  logic held_d;
  logic wr;
  logic [31:0] rd_mux;

  // Byte-lane merge of a write into an old value
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        merge[8*b +: 8] = nw[8*b +: 8];
      end
    end
  endfunction

  // Settings outside their range are pinned to the nearest limit
  function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    if (v < lo) begin
      clamp = lo;
    end else if (v > hi) begin
      clamp = hi;
    end else begin
      clamp = v;
    end
  endfunction

  assign en = s_q.ctrl[`VAM_CTRL_EN];

  // Used voltages all low; an empty mask never reads as low
  always_comb begin
    low_v = |s_q.ctrl[6:4];
    oc_hit = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (s_q.ctrl[4+i] && volt_i[i] >= s_q.trig) begin
        low_v = 1'b0; // R2
      end
      if (curr_i[i] > s_q.pick) begin
        oc_hit = 1'b1; // R3
      end
    end
  end

  // Blocking taken at the tick, held until the next one
  assign blk_now = tick_i ? blk_i : s_q.blk; // R9
  assign cond = en && low_v && (!s_q.ctrl[`VAM_CTRL_OCUSE] || oc_hit); // R1 R2 R3
  assign engage = tick_i && s_q.fsm == vam_pkg::VAM_IDLE && cond && !blk_now;

  // Timer is steered from here; stop also covers disable
  assign tif.tick = tick_i;
  assign tif.start = engage;
  assign tif.stop = s_q.fsm == vam_pkg::VAM_HELD && ((tick_i && blk_now) || !en); // R19
  assign tif.limit = s_q.hold;

  vam_hold_tmr u_tmr (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .t (tif)
  );

  vam_cal_sel u_cal (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .freq_i (s_q.sfreq),
    .idx_o (cal_pt_o)
  );

  // Register read decode
  always_comb begin
    if (wb_adr_i == `VAM_OFF_CTRL) begin
      rd_mux = {24'h000000, s_q.ctrl};
    end else if (wb_adr_i == `VAM_OFF_TRIG) begin
      rd_mux = {16'h0000, s_q.trig};
    end else if (wb_adr_i == `VAM_OFF_PICK) begin
      rd_mux = {16'h0000, s_q.pick};
    end else if (wb_adr_i == `VAM_OFF_HOLD) begin
      rd_mux = {16'h0000, s_q.hold};
    end else if (wb_adr_i == `VAM_OFF_NOM) begin
      rd_mux = {15'h0000, s_q.nom};
    end else if (wb_adr_i == `VAM_OFF_STAT) begin
      rd_mux = {21'h000000, s_q.fsm, 1'b0, s_q.unidir, s_q.flags};
    end else if (wb_adr_i == `VAM_OFF_EVT) begin
      rd_mux = {20'h00000, s_q.sticky};
    end else if (wb_adr_i == `VAM_OFF_SFRQ) begin
      rd_mux = {15'h0000, s_q.sfreq};
    end else begin
      rd_mux = 32'h00000000;
    end
  end

  // Write lands on the edge where the master sees ack
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && s_q.ack;

  // Whole next state of the block
  always_comb begin
    s_d = s_q;
    held_d = 1'b0;
    s_d.evt = 12'h000;
    // Bus slave, one wait state on every access
    s_d.ack = wb_cyc_i && wb_stb_i && !s_q.ack;
    if (s_d.ack && !wb_we_i) begin
      s_d.rdat = rd_mux;
    end
    if (wr) begin
      if (wb_adr_i == `VAM_OFF_CTRL) begin
        s_d.ctrl = 8'(merge({24'h000000, s_q.ctrl}, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == `VAM_OFF_TRIG) begin
        s_d.trig = 16'(clamp(merge({16'h0000, s_q.trig}, wb_dat_i, wb_sel_i) & 32'h0000ffff,
          `VAM_TRIG_MIN, `VAM_TRIG_MAX)); // R2
      end else if (wb_adr_i == `VAM_OFF_PICK) begin
        s_d.pick = 16'(merge({16'h0000, s_q.pick}, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == `VAM_OFF_HOLD) begin
        s_d.hold = 16'(clamp(merge({16'h0000, s_q.hold}, wb_dat_i, wb_sel_i) & 32'h0000ffff,
          `VAM_HOLD_MIN, `VAM_HOLD_MAX)); // R7
      end else if (wb_adr_i == `VAM_OFF_NOM) begin
        s_d.nom = 17'(clamp(merge({15'h0000, s_q.nom}, wb_dat_i, wb_sel_i) & 32'h0001ffff,
          `VAM_NOM_MIN, `VAM_NOM_MAX)); // R18
      end
    end
    if (tick_i) begin
      s_d.blk = blk_i; // R9
    end
    // Engagement sequence
    case (s_q.fsm)
      vam_pkg::VAM_IDLE: begin
        if (engage) begin
          s_d.fsm = vam_pkg::VAM_HELD;
          s_d.ang_hold = s_q.ang_prev; // R5
        end else if (tick_i) begin
          s_d.ang_prev = ang_i;
        end
      end
      vam_pkg::VAM_HELD: begin
        if (!en) begin
          s_d.fsm = vam_pkg::VAM_IDLE; // R1
        end else if (tick_i && blk_now) begin
          s_d.fsm = vam_pkg::VAM_WAIT; // R19
        end else if (tif.expired) begin
          s_d.fsm = vam_pkg::VAM_WAIT; // R7
          s_d.unidir = 1'b1; // R8
        end
      end
      vam_pkg::VAM_WAIT: begin
        // No re-engage until the low voltage has gone away or the function is disabled
        if (!en || (tick_i && !low_v)) begin
          s_d.fsm = vam_pkg::VAM_IDLE; // R19
          s_d.unidir = 1'b0;
        end
      end
      default: begin
        s_d.fsm = vam_pkg::VAM_IDLE;
      end
    endcase
    held_d = s_d.fsm == vam_pkg::VAM_HELD; // R6
    // Stage quantities: trigger level and frozen angles while held
    for (int i = 0; i < 3; i++) begin
      s_d.amp[i] = held_d ? s_d.trig : volt_i[i]; // R4
      s_d.ang_ref[i] = held_d ? s_d.ang_hold[i] : ang_i[i]; // R5
    end
    // Sampling source; frequency protection always sees the tracker
    s_d.ffct = s_q.ctrl[`VAM_CTRL_CTF] && low_v; // R10
    if (s_d.ffct) begin
      s_d.sfreq = il3_freq_i; // R10
    end else if (s_q.ctrl[`VAM_CTRL_TRACK]) begin
      s_d.sfreq = trk_freq_i; // R15 R16
    end else begin
      s_d.sfreq = s_q.nom; // R11 R15
    end
    s_d.ffreq = trk_freq_i; // R11
    // Condition flags and their on/off edges
    s_d.flags[`VAM_FL_EN] = en;
    s_d.flags[`VAM_FL_LOW] = low_v;
    s_d.flags[`VAM_FL_OC] = oc_hit;
    s_d.flags[`VAM_FL_CT] = s_d.ffct;
    s_d.flags[`VAM_FL_USE] = held_d;
    s_d.flags[`VAM_FL_BLK] = s_d.blk;
    for (int k = 0; k < 6; k++) begin
      s_d.evt[2*k] = s_d.flags[k] && !s_q.flags[k]; // R12 R13 R14
      s_d.evt[2*k+1] = !s_d.flags[k] && s_q.flags[k]; // R12 R13 R14
    end
    // Event log is write-one-to-clear; a new event beats the clear
    if (wr && wb_adr_i == `VAM_OFF_EVT) begin
      s_d.sticky = s_q.sticky & ~12'(merge(32'h00000000, wb_dat_i, wb_sel_i));
    end
    s_d.sticky = s_d.sticky | s_d.evt;
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.ctrl <= `VAM_CTRL_RST;
      s_q.trig <= `VAM_TRIG_RST;
      s_q.pick <= `VAM_PICK_RST;
      s_q.hold <= `VAM_HOLD_RST;
      s_q.nom <= `VAM_NOM_RST;
      s_q.fsm <= vam_pkg::VAM_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdat;
  assign amp_o = s_q.amp;
  assign ang_ref_o = s_q.ang_ref;
  assign mem_on_o = s_q.fsm == vam_pkg::VAM_HELD;
  assign unidir_o = s_q.unidir;
  assign freq_from_ct_o = s_q.ffct;
  assign samp_freq_o = s_q.sfreq;
  assign fprot_freq_o = s_q.ffreq;
  assign evt_o = s_q.evt;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_engage;
    $rose(mem_on_o);
  endsequence
  sequence s_blk_tick;
    tick_i && blk_i;
  endsequence

  property p_r1_off;
    !en |=> !mem_on_o;
  endproperty
  a_r1_off: assert property (p_r1_off) else $error("memory on while disabled"); // R1
  property p_r2_low;
    s_engage |-> $past(low_v) && $past(tick_i);
  endproperty
  a_r2_low: assert property (p_r2_low) else $error("engaged without low voltage"); // R2
  property p_r3_oc;
    s_engage ##0 $past(s_q.ctrl[`VAM_CTRL_OCUSE]) |-> $past(oc_hit);
  endproperty
  a_r3_oc: assert property (p_r3_oc) else $error("engaged without overcurrent"); // R3
  property p_r4_amp;
    mem_on_o |-> amp_o[0] == s_q.trig && amp_o[2] == s_q.trig;
  endproperty
  a_r4_amp: assert property (p_r4_amp) else $error("amplitude not trigger level"); // R4
  property p_r5_ang;
    s_engage |-> ang_ref_o == $past(s_q.ang_prev) ##1 (!mem_on_o || $stable(ang_ref_o));
  endproperty
  a_r5_ang: assert property (p_r5_ang) else $error("angle reference not latched"); // R5
  property p_r8_uni;
    $rose(unidir_o) |-> $past(tif.expired) && !mem_on_o;
  endproperty
  a_r8_uni: assert property (p_r8_uni) else $error("unidirectional without expiry"); // R8
  property p_r9_blk;
    !tick_i |=> $stable(s_q.blk);
  endproperty
  a_r9_blk: assert property (p_r9_blk) else $error("blocking resampled off tick"); // R9
  property p_r19_blk;
    mem_on_o ##0 s_blk_tick |=> !mem_on_o [*2];
  endproperty
  a_r19_blk: assert property (p_r19_blk) else $error("block did not release memory"); // R19
  property p_r10_ct;
    freq_from_ct_o |-> samp_freq_o == $past(il3_freq_i);
  endproperty
  a_r10_ct: assert property (p_r10_ct) else $error("sampling not from L3 current"); // R10
  property p_r11_fix;
    !$past(rst_i) && !freq_from_ct_o && !$past(s_q.ctrl[`VAM_CTRL_TRACK]) |-> samp_freq_o == $past(s_q.nom);
  endproperty
  a_r11_fix: assert property (p_r11_fix) else $error("fixed frequency not used"); // R11
  property p_r14_evt;
    s_engage |-> evt_o[2*`VAM_FL_USE] ##1 !evt_o[2*`VAM_FL_USE];
  endproperty
  a_r14_evt: assert property (p_r14_evt) else $error("memory use event missing"); // R14
  // Each flag edge must show up as its event; flags lag their source by one edge, the current follow and memory use flags excepted
  property p_r12_en;
    $rose(en) |=> evt_o[2*`VAM_FL_EN];
  endproperty
  a_r12_en: assert property (p_r12_en) else $error("enable event missing"); // R12
  property p_r12_low;
    $rose(low_v) |=> evt_o[2*`VAM_FL_LOW];
  endproperty
  a_r12_low: assert property (p_r12_low) else $error("low voltage event missing"); // R12
  property p_r13_oc;
    $fell(oc_hit) |=> evt_o[2*`VAM_FL_OC+1];
  endproperty
  a_r13_oc: assert property (p_r13_oc) else $error("overcurrent off event missing"); // R13
  property p_r13_ct;
    $rose(freq_from_ct_o) |-> evt_o[2*`VAM_FL_CT];
  endproperty
  a_r13_ct: assert property (p_r13_ct) else $error("current follow event missing"); // R13
  property p_r14_blk;
    tick_i && blk_i && !s_q.blk |=> evt_o[2*`VAM_FL_BLK];
  endproperty
  a_r14_blk: assert property (p_r14_blk) else $error("blocking event missing"); // R14
  property p_r6_off;
    $fell(mem_on_o) |-> evt_o[2*`VAM_FL_USE+1];
  endproperty
  a_r6_off: assert property (p_r6_off) else $error("memory off event missing"); // R6
  // Release paths: expiry only from held, wait never jumps straight back to held
  property p_r7_exp;
    $rose(unidir_o) |-> $past(mem_on_o);
  endproperty
  a_r7_exp: assert property (p_r7_exp) else $error("expiry outside engagement"); // R7
  property p_r19_wait;
    s_q.fsm == vam_pkg::VAM_WAIT |=> !mem_on_o;
  endproperty
  a_r19_wait: assert property (p_r19_wait) else $error("re-engaged from wait"); // R19
  property p_r20_run;
    s_engage |-> tif.running;
  endproperty
  a_r20_run: assert property (p_r20_run) else $error("hold timer not running"); // R20
  property p_r11_prot;
    !$past(rst_i) |-> fprot_freq_o == $past(trk_freq_i);
  endproperty
  a_r11_prot: assert property (p_r11_prot) else $error("frequency protection not tracked"); // R11
endmodule // vam_ctrl

// *** vam_regs.svh ***
// Register offsets, fields, reset values and timing constants of the voltage angle memory controller
// Summary of operation
// R1 - Memory engages only while the enable control bit is set.
// R2 - Low voltage means every used voltage below trigger setting, 2 to 50 V.
// R3 - With qualifier on, one phase current must also exceed pick-up setting.
// R4 - While engaged, amplitude output equals the trigger voltage setting.
// R5 - Angles of the tick before engagement are latched and output while engaged.
// R6 - Memory-in-use output stands for the whole engaged interval.
// R7 - An engagement not released earlier by blocking or disable ends after the hold limit, 0.02 to 50.00 s.
// R8 - On hold expiry, directional stages are told to go unidirectional.
// R9 - Blocking input sampled once per program tick, held for the cycle.
// R10 - Current follow on and voltages absent: sampling follows phase L3 current.
// R11 - Fixed mode: stage sampling uses the fixed frequency, frequency protection excepted.
// R12 - On/off events for enable change and low-voltage flag change.
// R13 - On/off events for overcurrent flag and current frequency following.
// R14 - On/off events for memory use and blocking.
// R15 - Sampling mode selects tracked frequency or fixed user frequency.
// R16 - Tracking mode: sampling frequency equals measured system frequency.
// R17 - Correction point chosen among eight calibrated frequency points.
// R18 - Fixed frequency in 0.001 Hz steps, default 50 Hz.
// R19 - Blocking releases memory early; re-engage only after low voltage clears. Disable also leaves wait, so re-enabling can re-engage while still low.
// R20 - Hold timer counts whole ticks, hold time rounded up.
`ifndef VAM_REGS_SVH
`define VAM_REGS_SVH
`define VAM_OFF_CTRL 8'h00
`define VAM_OFF_TRIG 8'h04
`define VAM_OFF_PICK 8'h08
`define VAM_OFF_HOLD 8'h0c
`define VAM_OFF_NOM 8'h10
`define VAM_OFF_STAT 8'h14
`define VAM_OFF_EVT 8'h18
`define VAM_OFF_SFRQ 8'h1c
`define VAM_CTRL_EN 0
`define VAM_CTRL_OCUSE 1
`define VAM_CTRL_CTF 2
`define VAM_CTRL_TRACK 3
`define VAM_CTRL_RST 8'h70
`define VAM_TRIG_MIN 32'h000000c8
`define VAM_TRIG_MAX 32'h00001388
`define VAM_TRIG_RST 16'h03e8
`define VAM_PICK_RST 16'h0064
`define VAM_HOLD_MIN 32'h00000002
`define VAM_HOLD_MAX 32'h00001388
`define VAM_HOLD_RST 16'h0032
`define VAM_NOM_MIN 32'h00001b58
`define VAM_NOM_MAX 32'h000124f8
`define VAM_NOM_RST 17'h0c350
`define VAM_TICK_US 32'h00001388
`define VAM_HOLD_STEP_US 32'h00002710
`define VAM_FL_EN 0
`define VAM_FL_LOW 1
`define VAM_FL_OC 2
`define VAM_FL_CT 3
`define VAM_FL_USE 4
`define VAM_FL_BLK 5
`define VAM_CAL_BP1 17'h03a98
`define VAM_CAL_BP2 17'h061a8
`define VAM_CAL_BP3 17'h088b8
`define VAM_CAL_BP4 17'h0afc8
`define VAM_CAL_BP5 17'h0d6d8
`define VAM_CAL_BP6 17'h0fde8
`define VAM_CAL_BP7 17'h11b34
`endif

// *** vam_pkg.sv ***
// Types of the voltage angle memory controller
package vam_pkg;
  typedef enum logic [2:0] {
    VAM_IDLE = 3'b001,
    VAM_HELD = 3'b010,
    VAM_WAIT = 3'b100
  } vam_state_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [7:0] ctrl;
    logic [15:0] trig;
    logic [15:0] pick;
    logic [15:0] hold;
    logic [16:0] nom;
    logic [11:0] sticky;
    vam_state_t fsm;
    logic blk;
    logic unidir;
    logic ffct;
    logic [5:0] flags;
    logic [11:0] evt;
    logic [2:0][15:0] ang_prev;
    logic [2:0][15:0] ang_hold;
    logic [2:0][15:0] amp;
    logic [2:0][15:0] ang_ref;
    logic [16:0] sfreq;
    logic [16:0] ffreq;
  } vam_top_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic exp;
    logic run;
  } vam_tmr_t;

  typedef struct packed {
    logic [2:0] idx;
  } vam_cal_t;
endpackage

// *** vam_tmr_if.sv ***
// Hold timer control and status bundle
interface vam_tmr_if;
  logic tick;
  logic start;
  logic stop;
  logic [15:0] limit;
  logic expired;
  logic running;
  modport ctl (output tick, output start, output stop, output limit, input expired, input running);
  modport tmr (input tick, input start, input stop, input limit, output expired, output running);
endinterface

// *** vam_hold_tmr.sv ***
// Definite-time hold timer counting program ticks
`include "vam_regs.svh"
module vam_hold_tmr (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  vam_tmr_if.tmr t // Timer control
);
  vam_pkg::vam_tmr_t t_q;
  vam_pkg::vam_tmr_t t_d;
  logic [31:0] cyc;

  // Hold in 10 ms steps to ticks, rounded up
  assign cyc = (32'(t.limit) * `VAM_HOLD_STEP_US + `VAM_TICK_US - 32'h1) / `VAM_TICK_US; // R20

  // Stop beats start; the two never meet, since stop is raised only while held and start only from idle
  always_comb begin
    t_d = t_q;
    t_d.exp = 1'b0;
    if (t.stop) begin
      t_d.run = 1'b0;
      t_d.cnt = 16'h0000;
    end else if (t.start) begin
      t_d.cnt = cyc[15:0]; // R7
      t_d.run = 1'b1;
    end else if (t_q.run && t.tick) begin
      if (t_q.cnt == 16'h0001) begin
        t_d.exp = 1'b1; // R7
        t_d.run = 1'b0;
        t_d.cnt = 16'h0000;
      end else begin
        t_d.cnt = t_q.cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      t_q <= '0;
    end else begin
      t_q <= t_d;
    end
  end

  assign t.expired = t_q.exp;
  assign t.running = t_q.run;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_tmr_load;
    t.start && !t.stop |=> t_q.cnt == $past(cyc[15:0]) && t_q.run;
  endproperty
  a_tmr_load: assert property (p_tmr_load) else $error("hold count not loaded"); // R20
  property p_tmr_nz;
    t_q.run |-> t_q.cnt != 16'h0000;
  endproperty
  a_tmr_nz: assert property (p_tmr_nz) else $error("running timer at zero"); // R7
endmodule // vam_hold_tmr

// *** vam_cal_sel.sv ***
// Selects one of eight calibrated correction points from the sampling frequency
`include "vam_regs.svh"
module vam_cal_sel (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic [16:0] freq_i, // Sampling frequency, mHz
  output logic [2:0] idx_o // Correction point index
);
  vam_pkg::vam_cal_t c_q;
  vam_pkg::vam_cal_t c_d;
  logic [7:1] hit;

  // Breakpoints midway between calibrated points
  function automatic logic [16:0] bp(input int i);
    case (i)
      1: bp = `VAM_CAL_BP1;
      2: bp = `VAM_CAL_BP2;
      3: bp = `VAM_CAL_BP3;
      4: bp = `VAM_CAL_BP4;
      5: bp = `VAM_CAL_BP5;
      6: bp = `VAM_CAL_BP6;
      default: bp = `VAM_CAL_BP7;
    endcase
  endfunction

  genvar g;
  generate
    for (g = 1; g < 8; g++) begin : g_cmp
      assign hit[g] = freq_i >= bp(g); // R17
    end
  endgenerate

  // Breakpoints ascend, so the hit count is the index
  always_comb begin
    c_d.idx = 3'h0;
    for (int i = 1; i < 8; i++) begin
      c_d.idx = c_d.idx + {2'b00, hit[i]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      c_q <= '0;
    end else begin
      c_q <= c_d;
    end
  end

  assign idx_o = c_q.idx;
endmodule // vam_cal_sel

// *** vam_meas_model.sv ***
// Measurement channel and program tick model facing the angle memory controller
module vam_meas_model #(
  parameter int TICK_CYC = 10
) (
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset
  input wire logic [2:0] low_i, // Channels in fault
  input wire logic chi_i, // Phase currents above pick-up
  output logic tick_o, // Program tick pulse
  output logic [2:0][15:0] volt_o, // Voltage magnitudes
  output logic [2:0][15:0] curr_o, // Phase currents
  output logic [2:0][15:0] ang_o, // Voltage angles
  output logic [16:0] trk_o, // Tracked frequency
  output logic [16:0] il3_o // L3 current frequency
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  // Angles step after every tick so a stale or early latch shows up
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 0;
      tick_o <= 1'b0;
      ang_o <= {16'h0300, 16'h0200, 16'h0100};
    end else begin
      cnt <= (cnt == TICK_CYC - 1) ? 0 : cnt + 1;
      tick_o <= (cnt == TICK_CYC - 1);
      if (tick_o) begin
        for (int k = 0; k < 3; k++) begin
          ang_o[k] <= ang_o[k] + 16'h0111;
        end
      end
    end
  end
  // Faulted channels collapse to 0.5 V, healthy ones sit at 100 V
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      volt_o[k] = low_i[k] ? 16'h0032 : 16'h2710;
      curr_o[k] = chi_i ? 16'h01f4 : 16'h0032;
    end
  end
  assign trk_o = 17'h0ea60;
  assign il3_o = 17'h09c40;
endmodule // vam_meas_model

// *** vam_tb.sv ***
// Self-checking bench for the voltage angle memory controller
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic wr;
    logic [7:0] adr;
    logic [31:0] dat;
    logic [31:0] exp;
  } vam_row_t;
  logic clk, rst, we, cyc, stb, ack, tick, blk, mem_on, unidir, fct, chi;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [2:0] low, calpt;
  logic [2:0][15:0] volt, curr, ang, amp, aref, ang_p1, ang_p2;
  logic [16:0] trk, il3, sfreq, pfreq;
  logic [11:0] evt;
  int bad_count, num_checks, nt;
  // Reset values, clamping at both ends, unmapped and read-only places
  vam_row_t rows [14] = '{
    '{1'b0, 8'h00, 32'h0, 32'h70}, '{1'b0, 8'h04, 32'h0, 32'h3e8},
    '{1'b0, 8'h08, 32'h0, 32'h64}, '{1'b0, 8'h0c, 32'h0, 32'h32},
    '{1'b0, 8'h10, 32'h0, 32'hc350}, '{1'b1, 8'h04, 32'h1, 32'hc8},
    '{1'b1, 8'h04, 32'h1400, 32'h1388}, '{1'b1, 8'h0c, 32'h1, 32'h2},
    '{1'b1, 8'h0c, 32'h1400, 32'h1388}, '{1'b1, 8'h10, 32'h64, 32'h1b58},
    '{1'b1, 8'h10, 32'h15000, 32'h124f8}, '{1'b1, 8'h08, 32'h1234, 32'h1234},
    '{1'b1, 8'h20, 32'habcd, 32'h0}, '{1'b1, 8'h1c, 32'h1234, 32'h124f8}};

  vam_ctrl dut_u (.clk_i(clk), .rst_i(rst), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .tick_i(tick),
    .blk_i(blk), .volt_i(volt), .curr_i(curr), .ang_i(ang), .trk_freq_i(trk), .il3_freq_i(il3),
    .amp_o(amp), .ang_ref_o(aref), .mem_on_o(mem_on), .unidir_o(unidir), .freq_from_ct_o(fct),
    .samp_freq_o(sfreq), .fprot_freq_o(pfreq), .cal_pt_o(calpt), .evt_o(evt));
  vam_meas_model meas_u (.clk_i(clk), .rst_i(rst), .low_i(low), .chi_i(chi), .tick_o(tick),
    .volt_o(volt), .curr_o(curr), .ang_o(ang), .trk_o(trk), .il3_o(il3));

  // Clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Angles seen at the last two ticks, for the latch prediction
  always @(posedge clk) begin
    if (tick === 1'b1) begin
      ang_p1 <= ang;
      ang_p2 <= ang_p1;
    end
  end

  task automatic end_sim();
    if (bad_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Classic single cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int i;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 20);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1) begin
      chk("ack wait", ack, 1'b1);
      end_sim();
    end
  endtask
  // Waits for the memory flag, counting ticks on the way
  task automatic wait_on(input logic v, output int n);
    int i;
    n = 0;
    i = 0;
    do begin
      @(posedge clk);
      i++;
      if (tick === 1'b1) n++;
    end while (mem_on !== v && i < 100);
    if (mem_on !== v) begin
      chk("mem_on wait", mem_on, v);
      end_sim();
    end
  endtask
  task automatic ticks(input int n);
    repeat (n * 10) @(posedge clk);
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    {we, cyc, stb, blk, chi} = '0;
    adr = '0;
    wdat = '0;
    sel = 4'hf;
    low = '0;
    repeat (3) @(posedge clk);
    chk("mem_on rst", mem_on, 1'b0);
    chk("unidir rst", unidir, 1'b0);
    chk("evt rst", {ack, evt, sfreq}, '0);
    rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wb(1'b1, rows[i].adr, rows[i].dat, q);
      end
      wb(1'b0, rows[i].adr, 32'h0, q);
      chk($sformatf("reg %h", rows[i].adr), q, rows[i].exp);
    end
    wb(1'b1, 8'h04, 32'h3e8, q);
    wb(1'b1, 8'h0c, 32'h2, q);
    wb(1'b1, 8'h10, 32'hc350, q);
    wb(1'b1, 8'h08, 32'h64, q);
    // Qualifier on, enable off
    low <= 3'b111;
    chi <= 1'b1;
    wb(1'b1, 8'h00, 32'h72, q);
    ticks(3);
    chk("mem_on off", mem_on, 1'b0);
    low <= 3'b011;
    wb(1'b1, 8'h00, 32'h73, q);
    ticks(3);
    chk("mem_on one high", mem_on, 1'b0);
    low <= 3'b111;
    chi <= 1'b0;
    ticks(3);
    chk("mem_on no current", mem_on, 1'b0);
    chi <= 1'b1;
    wait_on(1'b1, nt);
    chk("amp", amp, {3{16'h03e8}});
    chk("ang_ref", aref, ang_p2);
    q = aref;
    wait_on(1'b0, nt);
    chk("hold ticks", nt, 4);
    chk("unidir", unidir, 1'b1);
    wb(1'b0, 8'h18, 32'h0, q);
    chk("evt engage", q & 32'h315, 32'h315);
    wb(1'b1, 8'h18, 32'hfff, q);
    ticks(3);
    chk("no rearm", mem_on, 1'b0);
    // Current follow while voltages are gone
    wb(1'b1, 8'h00, 32'h77, q);
    repeat (4) @(posedge clk);
    chk("freq_from_ct", fct, 1'b1);
    chk("samp il3", sfreq, 17'h09c40);
    chk("cal il3", calpt, 3'h3);
    chk("fprot", pfreq, 17'h0ea60);
    low <= 3'b000;
    repeat (4) @(posedge clk);
    chk("freq_from_ct off", fct, 1'b0);
    chk("samp nom", sfreq, 17'h0c350);
    chk("cal nom", calpt, 3'h4);
    wb(1'b0, 8'h18, 32'h0, q);
    chk("evt ct", q & 32'hc8, 32'hc8);
    wb(1'b1, 8'h18, 32'hfff, q);
    wb(1'b1, 8'h00, 32'h7b, q);
    repeat (4) @(posedge clk);
    chk("samp trk", sfreq, 17'h0ea60);
    chk("cal trk", calpt, 3'h5);
    // Blocking between ticks takes effect only at the next tick
    wb(1'b1, 8'h00, 32'h73, q);
    low <= 3'b111;
    wait_on(1'b1, nt);
    wait_on(1'b1, nt);
    @(posedge clk);
    blk <= 1'b1;
    repeat (5) @(posedge clk);
    chk("mem_on before tick", mem_on, 1'b1);
    wait_on(1'b0, nt);
    chk("block ticks", nt, 1);
    chk("unidir block", unidir, 1'b0);
    blk <= 1'b0;
    ticks(3);
    chk("no rearm blk", mem_on, 1'b0);
    wb(1'b0, 8'h18, 32'h0, q);
    chk("evt blk", q & 32'hf00, 32'hf00);
    low <= 3'b000;
    ticks(2);
    low <= 3'b111;
    wait_on(1'b1, nt);
    wb(1'b1, 8'h00, 32'h72, q);
    repeat (2) @(posedge clk);
    chk("disable drop", mem_on, 1'b0);
    end_sim();
  end
endmodule // testbench
